/* hdl/dbio_cfg.svh */
/*
 * register offsets, field positions and reset values of the board i/o register block.
 * assumes byte-wide host i/o cycles with offsets already stripped of the base address.
 */
`ifndef DBIO_CFG_SVH
`define DBIO_CFG_SVH

// ==========================================
// offsets
`define DBIO_OFF_PORT0 8'hC0
`define DBIO_OFF_PORT1 8'hC4
`define DBIO_OFF_PORT2 8'hC8
`define DBIO_OFF_DIR0 8'hCC
`define DBIO_OFF_PORT3 8'hD0
`define DBIO_OFF_PORT4 8'hD4
`define DBIO_OFF_PORT5 8'hD8
`define DBIO_OFF_DIR1 8'hDC
`define DBIO_OFF_TCNT0 8'hE0
`define DBIO_OFF_TCNT1 8'hE4
`define DBIO_OFF_TCNT2 8'hE8
`define DBIO_OFF_TCTRL 8'hEC
`define DBIO_OFF_CLKIRQ 8'hF0
`define DBIO_OFF_BOARDID 8'hF4

// ==========================================
// direction word fields
`define DBIO_DIR_PA 4
`define DBIO_DIR_PCH 3
`define DBIO_DIR_PB 1
`define DBIO_DIR_PCL 0
`define DBIO_DIR_RESET 8'h9B
`define DBIO_DIR_ALL_OUT 8'h80

// ==========================================
// clock/irq control fields
`define DBIO_CI_CLKSEL 0
`define DBIO_CI_INV2 1
`define DBIO_CI_SEL0_LO 2
`define DBIO_CI_SEL1_LO 4
`define DBIO_CI_MASK 8'h3F
`define DBIO_CI_RESET 8'h00
`define DBIO_PORT_RESET 8'h00

// ==========================================
// timer control word fields
`define DBIO_TC_SC_LO 6
`define DBIO_TC_RL_LO 4
`define DBIO_TC_M_LO 1
`define DBIO_TC_BCD 0
`define DBIO_TC_RESET 8'h00

`endif

/* hdl/dbio_pkg.sv */
/*
 * types of the board i/o register block.
 * assumes dbio_cfg.svh for all numbers.
 */
package dbio_pkg;

	// host byte i/o request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dbio_req_t;

	// one group of three ports: a, b, c
	typedef struct packed {
		logic [7:0] pc;
		logic [7:0] pb;
		logic [7:0] pa;
	} dbio_grp_t;

	// access order field of the timer control word
	typedef enum logic [1:0] {
		DBIO_ACC_LATCH,
		DBIO_ACC_LOW,
		DBIO_ACC_HIGH,
		DBIO_ACC_LOW_HIGH
	} dbio_acc_t;

	// decoded timer control word
	typedef struct packed {
		logic [1:0] counter_sel;
		dbio_acc_t access_order;
		logic [2:0] counting_mode;
		logic bcd;
	} dbio_tctrl_t;

	// access state of the timer data port
	typedef enum logic [1:0] {
		DBIO_TS_IDLE,
		DBIO_TS_LOW,
		DBIO_TS_HIGH
	} dbio_tstate_t;

endpackage

/* hdl/dbio_regs.sv */
/*
 * host-visible register block of a 48-channel digital i/o board: six byte ports in
 * two groups, pass-through to a three-channel counter/timer, clock/irq source control,
 * board id.
 * assumes the host issues single-cycle byte reads and writes on clk; the timer core
 * sits outside and answers reads combinationally.
 */
`timescale 1ns/1ps
`include "dbio_cfg.svh"

module dbio_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host byte i/o
	input wire dbio_pkg::dbio_req_t host_req,
	output logic [7:0] host_rdata,
	// board enable and identification
	input wire logic board_enable,
	input wire logic [3:0] board_tag,
	// digital port pins
	input wire dbio_pkg::dbio_grp_t grp0_pin_in,
	input wire dbio_pkg::dbio_grp_t grp1_pin_in,
	output dbio_pkg::dbio_grp_t grp0_pin_out,
	output dbio_pkg::dbio_grp_t grp1_pin_out,
	output dbio_pkg::dbio_grp_t grp0_pin_oe,
	output dbio_pkg::dbio_grp_t grp1_pin_oe,
	// counter/timer core
	output dbio_pkg::dbio_tctrl_t timer_ctrl,
	output logic timer_ctrl_wr,
	output logic timer_readback_cmd,
	output logic [1:0] timer_cnt_sel,
	output logic [7:0] timer_wdata,
	output logic timer_wr,
	output logic timer_rd,
	output logic timer_byte_high,
	output logic timer_latch,
	input wire logic [7:0] timer_rdata,
	output logic timer_clock_select,
	// interrupt source lines
	output logic event_line_zero,
	output logic event_line_one,
	output logic event_line_two
);

	// ==========================================
	// register state
	logic [7:0] dir0_q, dir0_d, dir1_q, dir1_d;
	dbio_pkg::dbio_grp_t out0_q, out0_d, out1_q, out1_d;
	logic [7:0] tctrl_q, tctrl_d, clkirq_q, clkirq_d;
	dbio_pkg::dbio_tstate_t tstate_q [3], tstate_d [3];
	logic [7:0] rdata_d;
	logic wr, rd;
	dbio_pkg::dbio_acc_t acc;
	dbio_pkg::dbio_grp_t oe0, oe1, rd0, rd1;

	assign wr = host_req.wr;
	assign rd = host_req.rd;
	assign acc = dbio_pkg::dbio_acc_t'(tctrl_q[`DBIO_TC_RL_LO +: 2]);

	// direction bits expand to per-pin enables; zero bit means output
	function automatic dbio_pkg::dbio_grp_t dir_oe(input logic [7:0] dw, input logic en);
		dbio_pkg::dbio_grp_t o;
		o.pa = {8{en & ~dw[`DBIO_DIR_PA]}};
		o.pb = {8{en & ~dw[`DBIO_DIR_PB]}};
		o.pc = {{4{en & ~dw[`DBIO_DIR_PCH]}}, {4{en & ~dw[`DBIO_DIR_PCL]}}};
		return o;
	endfunction

	// event source: 01 off, 10 pc3, 00 or 11 pc3 and not pc7
	function automatic logic ev_src(input logic [1:0] sel, input logic [7:0] pc);
		logic r;
		r = 1'b0;
		case (sel)
			2'h1: r = 1'b0;
			2'h2: r = pc[3];
			default: r = pc[3] & ~pc[7];
		endcase
		return r;
	endfunction

	assign oe0 = dir_oe(dir0_q, board_enable);
	assign oe1 = dir_oe(dir1_q, board_enable);
	// read merges pins on input bits with latched value on output bits
	assign rd0 = (grp0_pin_in & ~oe0) | (out0_q & oe0);
	assign rd1 = (grp1_pin_in & ~oe1) | (out1_q & oe1);

	// ==========================================
	// host writes
	always_comb begin
		dir0_d = dir0_q;
		dir1_d = dir1_q;
		out0_d = out0_q;
		out1_d = out1_q;
		tctrl_d = tctrl_q;
		clkirq_d = clkirq_q;
		if (wr) begin
			case (host_req.addr)
				`DBIO_OFF_DIR0: dir0_d = host_req.wdata;
				`DBIO_OFF_DIR1: dir1_d = host_req.wdata;
				`DBIO_OFF_PORT0: if (board_enable) out0_d.pa = host_req.wdata;
				`DBIO_OFF_PORT1: if (board_enable) out0_d.pb = host_req.wdata;
				`DBIO_OFF_PORT2: if (board_enable) out0_d.pc = host_req.wdata;
				`DBIO_OFF_PORT3: if (board_enable) out1_d.pa = host_req.wdata;
				`DBIO_OFF_PORT4: if (board_enable) out1_d.pb = host_req.wdata;
				`DBIO_OFF_PORT5: if (board_enable) out1_d.pc = host_req.wdata;
				`DBIO_OFF_TCTRL: begin
					// read-back and latch commands leave the stored mode alone
					if (host_req.wdata[`DBIO_TC_SC_LO +: 2] != 2'h3 &&
						host_req.wdata[`DBIO_TC_RL_LO +: 2] != 2'h0) begin
						tctrl_d = host_req.wdata;
					end
				end
				`DBIO_OFF_CLKIRQ: clkirq_d = host_req.wdata & `DBIO_CI_MASK;
				default: ;
			endcase
		end
	end

	// ==========================================
	// timer byte sequencing per counter
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			tstate_d[i] = tstate_q[i];
		end
		if (wr && host_req.addr == `DBIO_OFF_TCTRL) begin
			if (host_req.wdata[`DBIO_TC_SC_LO +: 2] != 2'h3) begin
				tstate_d[host_req.wdata[`DBIO_TC_SC_LO +: 2]] = dbio_pkg::DBIO_TS_LOW;
			end
		end else if ((wr || rd) && timer_cnt_sel != 2'h3 && timer_wr | timer_rd) begin
			case (acc)
				dbio_pkg::DBIO_ACC_LOW_HIGH: begin
					tstate_d[timer_cnt_sel] = (tstate_q[timer_cnt_sel] == dbio_pkg::DBIO_TS_HIGH) ?
						dbio_pkg::DBIO_TS_LOW : dbio_pkg::DBIO_TS_HIGH;
				end
				default: ;
			endcase
		end
	end

	// decode of the timer data offsets
	always_comb begin
		case (host_req.addr)
			`DBIO_OFF_TCNT0: timer_cnt_sel = 2'h0;
			`DBIO_OFF_TCNT1: timer_cnt_sel = 2'h1;
			`DBIO_OFF_TCNT2: timer_cnt_sel = 2'h2;
			default: timer_cnt_sel = 2'h3;
		endcase
	end

	assign timer_wr = wr & (timer_cnt_sel != 2'h3);
	assign timer_rd = rd & (timer_cnt_sel != 2'h3);
	assign timer_wdata = host_req.wdata;
	// byte lane chosen by access order and sequence position
	always_comb begin
		case (acc)
			dbio_pkg::DBIO_ACC_HIGH: timer_byte_high = 1'b1;
			dbio_pkg::DBIO_ACC_LOW_HIGH: timer_byte_high = (timer_cnt_sel != 2'h3) &&
				(tstate_q[timer_cnt_sel] == dbio_pkg::DBIO_TS_HIGH);
			default: timer_byte_high = 1'b0;
		endcase
	end
	assign timer_ctrl_wr = wr & (host_req.addr == `DBIO_OFF_TCTRL);
	assign timer_readback_cmd = timer_ctrl_wr &
		(host_req.wdata[`DBIO_TC_SC_LO +: 2] == 2'h3);
	assign timer_latch = timer_ctrl_wr & ~timer_readback_cmd &
		(host_req.wdata[`DBIO_TC_RL_LO +: 2] == 2'h0);
	assign timer_ctrl = dbio_pkg::dbio_tctrl_t'(timer_ctrl_wr ? host_req.wdata : tctrl_q);
	assign timer_clock_select = clkirq_q[`DBIO_CI_CLKSEL];

	// ==========================================
	// read mux, registered one cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		if (rd) begin
			case (host_req.addr)
				`DBIO_OFF_PORT0: rdata_d = board_enable ? rd0.pa : 8'h00;
				`DBIO_OFF_PORT1: rdata_d = board_enable ? rd0.pb : 8'h00;
				`DBIO_OFF_PORT2: rdata_d = board_enable ? rd0.pc : 8'h00;
				`DBIO_OFF_PORT3: rdata_d = board_enable ? rd1.pa : 8'h00;
				`DBIO_OFF_PORT4: rdata_d = board_enable ? rd1.pb : 8'h00;
				`DBIO_OFF_PORT5: rdata_d = board_enable ? rd1.pc : 8'h00;
				`DBIO_OFF_TCNT0, `DBIO_OFF_TCNT1, `DBIO_OFF_TCNT2: rdata_d = timer_rdata;
				`DBIO_OFF_TCTRL: rdata_d = tctrl_q;
				`DBIO_OFF_CLKIRQ: rdata_d = clkirq_q;
				`DBIO_OFF_BOARDID: rdata_d = {4'h0, board_tag};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			dir0_q <= `DBIO_DIR_RESET;
			dir1_q <= `DBIO_DIR_RESET;
			out0_q <= '0;
			out1_q <= '0;
			tctrl_q <= `DBIO_TC_RESET;
			clkirq_q <= `DBIO_CI_RESET;
			host_rdata <= 8'h00;
			for (int i = 0; i < 3; i++) begin
				tstate_q[i] <= dbio_pkg::DBIO_TS_IDLE;
			end
		end else begin
			dir0_q <= dir0_d;
			dir1_q <= dir1_d;
			out0_q <= out0_d;
			out1_q <= out1_d;
			tctrl_q <= tctrl_d;
			clkirq_q <= clkirq_d;
			host_rdata <= rdata_d;
			for (int i = 0; i < 3; i++) begin
				tstate_q[i] <= tstate_d[i];
			end
		end
	end

	// ==========================================
	// pins and event lines
	assign grp0_pin_oe = oe0;
	assign grp1_pin_oe = oe1;
	assign grp0_pin_out = out0_q;
	assign grp1_pin_out = out1_q;
	assign event_line_zero = ev_src(clkirq_q[`DBIO_CI_SEL0_LO +: 2], rd0.pc);
	assign event_line_one = ev_src(clkirq_q[`DBIO_CI_SEL1_LO +: 2], rd1.pc);
	assign event_line_two = rd0.pc[0] ^ clkirq_q[`DBIO_CI_INV2];

endmodule

/* dv/dbio_regs_checker.sv */
/* port assertions of the board i/o register block.
   assumes a bind to dbio_regs, one clock domain. */
`timescale 1ns/1ps
// ==========
// checker
module dbio_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host side
	input wire dbio_pkg::dbio_req_t host_req,
	input wire logic [7:0] host_rdata,
	input wire logic board_enable,
	input wire logic [3:0] board_tag,
	// pins and timer
	input wire dbio_pkg::dbio_grp_t grp0_pin_oe,
	input wire dbio_pkg::dbio_grp_t grp1_pin_oe,
	input wire logic timer_wr,
	input wire logic [1:0] timer_cnt_sel,
	input wire logic timer_clock_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic w;
	logic r;
	logic [7:0] a;
	logic [7:0] d;
	assign w = host_req.wr;
	assign r = host_req.rd;
	assign a = host_req.addr;
	assign d = host_req.wdata;
	a_reset_inputs: assert property ($fell(rst) |-> grp0_pin_oe == '0 && grp1_pin_oe == '0)
		else $error("driver on after reset");
	a_blocked_oe: assert property (!board_enable |-> grp0_pin_oe == '0 && grp1_pin_oe == '0)
		else $error("driver on while disabled");
	a_group0_out: assert property (w && a == 8'hCC && d == 8'h80 |=> !board_enable || grp0_pin_oe == '1)
		else $error("group 0 not output");
	a_group1_in: assert property (w && a == 8'hDC && d == 8'h9B |=> grp1_pin_oe == '0)
		else $error("group 1 not input");
	a_timer_strobe: assert property (w && a == 8'hE4 |-> timer_wr && timer_cnt_sel == 2'h1)
		else $error("counter 1 write lost");
	a_clock_pick: assert property (w && a == 8'hF0 |=> timer_clock_select == $past(d[0]))
		else $error("clock select wrong");
	a_irq_top_zero: assert property (r && a == 8'hF0 |=> host_rdata[7:6] == 2'h0)
		else $error("clock control top bits set");
	a_tag_read: assert property (r && a == 8'hF4 |=> host_rdata == {4'h0, $past(board_tag)})
		else $error("board id wrong");
	c_dir_write: cover property (w && a == 8'hCC);
	c_port_read: cover property (r && a == 8'hC0 && board_enable);
	c_id_read: cover property (r && a == 8'hF4);
endmodule
bind dbio_regs dbio_chk i_dbio_chk (.clk(clk), .rst(rst), .host_req(host_req),
	.host_rdata(host_rdata), .board_enable(board_enable), .board_tag(board_tag),
	.grp0_pin_oe(grp0_pin_oe), .grp1_pin_oe(grp1_pin_oe), .timer_wr(timer_wr),
	.timer_cnt_sel(timer_cnt_sel), .timer_clock_select(timer_clock_select));

/* dv/dbio_timer_model.sv */
/* behavioural counter/timer core: stores one byte per counter.
   assumes combinational read strobes from the register block. */
`timescale 1ns/1ps
// ==========
// timer model
module dbio_timer_model (
	// clock
	input wire logic clk,
	// strobes and data
	input wire logic timer_wr,
	input wire logic timer_rd,
	input wire logic [1:0] timer_cnt_sel,
	input wire logic [7:0] timer_wdata,
	output logic [7:0] timer_rdata
);
	logic [7:0] cnt_q [4];
	always_ff @(posedge clk) begin
		if (timer_wr) begin
			cnt_q[timer_cnt_sel] <= timer_wdata;
		end
	end
	// idle bus shows the inverse so a stale byte cannot pass
	assign timer_rdata = timer_rd ? cnt_q[timer_cnt_sel] : ~cnt_q[timer_cnt_sel];
endmodule

/* dv/dbio_regs_tb.sv */
/* self-checking bench of the board i/o register block.
   assumes dbio_regs, dbio_timer_model and the bound checker. */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
// ==========
// bench
module dbio_regs_tb;
	logic clk = 0;
	logic rst = 1;
	logic board_enable = 0;
	logic [3:0] board_tag = '0;
	dbio_pkg::dbio_req_t host_req = '0;
	dbio_pkg::dbio_grp_t pin0 = '0, pin1 = '0, oe0, oe1, out0, out1;
	dbio_pkg::dbio_tctrl_t tctrl, t_ctrl;
	logic [7:0] host_rdata, twd, trdata, rd, v;
	logic [1:0] csel;
	logic tcw, trb, tlat, twr, trd, tbh, t_rb, t_lat, t_bh, t_cw, ev0, ev1, ev2, clksel;
	int num_errors = 0;
	int comparisons = 0;
	always #4 clk = ~clk;
	dbio_regs i_dbio_regs (.clk(clk), .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
		.board_enable(board_enable), .board_tag(board_tag), .grp0_pin_in(pin0),
		.grp1_pin_in(pin1), .grp0_pin_out(out0), .grp1_pin_out(out1), .grp0_pin_oe(oe0),
		.grp1_pin_oe(oe1), .timer_ctrl(tctrl), .timer_ctrl_wr(tcw), .timer_readback_cmd(trb),
		.timer_cnt_sel(csel), .timer_wdata(twd), .timer_wr(twr), .timer_rd(trd),
		.timer_byte_high(tbh), .timer_latch(tlat), .timer_rdata(trdata),
		.timer_clock_select(clksel), .event_line_zero(ev0), .event_line_one(ev1),
		.event_line_two(ev2));
	dbio_timer_model i_dbio_timer_model (.clk(clk), .timer_wr(twr), .timer_rd(trd),
		.timer_cnt_sel(csel), .timer_wdata(twd), .timer_rdata(trdata));
	// one host byte cycle; timer strobes caught in the request cycle
	task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) host_req <= '{r, !r, a, d};
		#1 t_ctrl = tctrl;
		t_rb = trb;
		t_lat = tlat;
		t_bh = tbh;
		t_cw = tcw;
		@(posedge clk) host_req <= '0;
		#1 rd = host_rdata;
	endtask
	function automatic dbio_pkg::dbio_grp_t exp_oe(input logic [7:0] w);
		exp_oe = {{4{!w[3]}}, {4{!w[0]}}, {8{!w[1]}}, {8{!w[4]}}};
	endfunction
	function automatic logic exp_ev(input logic [1:0] s, input logic [7:0] c);
		exp_ev = (s == 2'h1) ? 1'b0 : (s == 2'h2) ? c[3] : c[3] & !c[7];
	endfunction
	task automatic port_grp(input logic g, input logic [7:0] w);
		dbio_pkg::dbio_grp_t o, p, e;
		logic [7:0] b;
		o = dbio_pkg::dbio_grp_t'(24'($urandom));
		p = dbio_pkg::dbio_grp_t'(24'($urandom));
		e = exp_oe(w);
		b = g ? 8'hD0 : 8'hC0;
		@(posedge clk);
		if (g) pin1 <= p; else pin0 <= p;
		acc(0, b + 8'h0C, w);
		for (int i = 0; i < 3; i++) acc(0, b + 8'(4 * i), o[8 * i +: 8]);
		`CHK(g ? oe1 : oe0, e)
		`CHK(g ? out1 : out0, o)
		for (int i = 0; i < 3; i++) begin
			acc(1, b + 8'(4 * i), 8'h00);
			`CHK(rd, (p[8 * i +: 8] & ~e[8 * i +: 8]) | (o[8 * i +: 8] & e[8 * i +: 8]))
		end
	endtask
	task automatic print_verdict();
		$display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		print_verdict();
	end
	initial begin
		void'($urandom(61));
		repeat (3) @(posedge clk);
		rst <= 0;
		acc(0, 8'hCC, 8'h80);
		`CHK({oe0, oe1}, 48'h0)
		acc(0, 8'hC0, 8'hFF);
		acc(1, 8'hC0, 8'h00);
		`CHK(rd, 8'h00)
		@(posedge clk) board_enable <= 1;
		for (int g = 0; g < 2; g++) begin
			port_grp(g[0], 8'h80);
			port_grp(g[0], 8'h80 | (8'($urandom) & 8'h1B));
			port_grp(g[0], 8'h9B);
		end
		acc(1, 8'hCC, 8'h00);
		`CHK(rd, 8'h00)
		for (int i = 0; i < 3; i++) begin
			v = $urandom;
			acc(0, 8'hE0 + 8'(4 * i), v);
			acc(1, 8'hE0 + 8'(4 * i), 8'h00);
			`CHK(rd, v)
		end
		for (int i = 0; i < 4; i++) begin
			v = {2'(i), 2'(i), 3'($urandom), 1'($urandom)};
			acc(0, 8'hEC, v);
			`CHK(t_ctrl, v)
			`CHK({t_rb, t_lat}, {i == 3, i == 0})
			`CHK(t_cw, 1'b1)
		end
		// last stored word selects high byte only
		acc(1, 8'hE8, 8'h00);
		`CHK(t_bh, 1'b1)
		// low then high: first access low byte, next high byte
		acc(0, 8'hEC, 8'h30);
		acc(0, 8'hE0, 8'h11);
		`CHK(t_bh, 1'b0)
		acc(0, 8'hE0, 8'h22);
		`CHK(t_bh, 1'b1)
		for (int i = 0; i < 6; i++) begin
			v = {2'h3, 2'(i % 3), 2'(i % 3), 1'(i / 3), 1'($urandom)};
			@(posedge clk) pin0 <= dbio_pkg::dbio_grp_t'(24'($urandom));
			pin1 <= dbio_pkg::dbio_grp_t'(24'($urandom));
			acc(0, 8'hF0, v);
			acc(1, 8'hF0, 8'h00);
			`CHK(rd, v & 8'h3F)
			`CHK(clksel, v[0])
			`CHK(ev2, pin0.pc[0] ^ v[1])
			`CHK(ev0, exp_ev(v[3:2], pin0.pc))
			`CHK(ev1, exp_ev(v[5:4], pin1.pc))
		end
		@(posedge clk) board_tag <= 4'($urandom);
		acc(0, 8'hF4, 8'hFF);
		acc(1, 8'hF4, 8'h00);
		`CHK(rd, {4'h0, board_tag})
		acc(0, 8'hCC, 8'h80);
		@(posedge clk) rst <= 1;
		@(posedge clk) rst <= 0;
		#1 `CHK({oe0, oe1}, 48'h0)
		print_verdict();
	end
endmodule
